// >>> src/hbw_pkg.sv
package hbw_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int DATA_W = 16;
   // ------------------------------------------------------------
   // timing counts in clk cycles; SPI_HDR and SPI_FRAME count serial bits
   // ------------------------------------------------------------
   localparam logic [3:0] STROBE_MIN = 4'h2;
   localparam logic [7:0] SPI_HALF   = 8'h04;
   localparam logic [7:0] SPI_GAP    = 8'h20;
   localparam logic [5:0] SPI_HDR    = 6'h10;
   localparam logic [5:0] SPI_FRAME  = 6'h20;
   // ------------------------------------------------------------
   // reset values of strap drivers (pull-up levels)
   // ------------------------------------------------------------
   localparam logic STYLE_RST = 1'b1;
   localparam logic WAIT_POLARITY_SELECT_RST  = 1'b1;
   localparam logic PORT_RST  = 1'b1;
   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      D_IDLE  = 5'h01,
      D_FETCH = 5'h02,
      D_SERVE = 5'h04,
      D_PREF  = 5'h08,
      D_WRITE = 5'h10
   } hbw_dev_e;
   typedef enum logic [4:0] {
      H_IDLE   = 5'h01,
      H_SETUP  = 5'h02,
      H_STROBE = 5'h04,
      H_END    = 5'h08,
      H_SPI    = 5'h10
   } hbw_host_e;
endpackage

// >>> src/hbw_if.sv
`timescale 1ns/1ps
interface hbw_if #(parameter int AW = 15, parameter int DW = 16);
   logic          chipSelN;
   logic [AW-1:0] addr;
   logic          writeDirN;
   logic          sharedRwPulseN;
   logic [DW-1:0] hostData;
   logic          hostDataOe;
   logic [DW-1:0] devData;
   logic          devDataOe;
   logic [DW-1:0] dataBus;
   logic          holdOff;
   logic          strobeStyleSelect;
   logic          waitPolaritySelect;
   logic          hostPortSelect;
   logic          spiCsN;
   logic          sck;
   logic          si;
   logic          so;
   logic          soOe;
   logic          misoLine;
   // ------------------------------------------------------------
   // wire resolution, pull-down when undriven
   // ------------------------------------------------------------
   assign dataBus  = devDataOe ? devData : (hostDataOe ? hostData : '0);
   assign misoLine = soOe & so;
   modport dev (
      input  chipSelN, addr, writeDirN, sharedRwPulseN, dataBus,
      input  strobeStyleSelect, waitPolaritySelect, hostPortSelect,
      input  spiCsN, sck, si,
      output devData, devDataOe, holdOff, so, soOe
   );
   modport host (
      output chipSelN, addr, writeDirN, sharedRwPulseN,
      output hostData, hostDataOe,
      output strobeStyleSelect, waitPolaritySelect, hostPortSelect,
      output spiCsN, sck, si,
      input  dataBus, holdOff, misoLine
   );
endinterface

// >>> src/hbw_dev.sv
`timescale 1ns/1ps
module hbw_dev
   import hbw_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   hbw_if.dev                 bus,
   output logic               coreReq,
   output logic               coreWrite,
   output logic [AW-1:0]      coreAddr,
   output logic [DW-1:0]      coreWdata,
   input  wire logic          coreAck,
   input  wire logic [DW-1:0] coreRdata
);
   hbw_dev_e      state, next_state;
   logic          strapWait, taken, style, wait_polarity_select, portPar;
   logic          next_taken, next_style, next_wait_polarity_select, next_portPar;
   logic          served, next_served;
   logic          pfValid, next_pfValid;
   logic [AW-1:0] pfAddr, next_pfAddr, curAddr, next_curAddr;
   logic [DW-1:0] pfData, next_pfData, dataOut, next_dataOut;
   logic          dataOe, next_dataOe, holdPin, next_holdPin;
   logic          next_coreReq, next_coreWrite;
   logic [AW-1:0] next_coreAddr;
   logic [DW-1:0] next_coreWdata;
   logic          sckPrev, spiLoaded, next_spiLoaded;
   logic          spiRead, next_spiRead, soOe, next_soOe;
   logic          pendRd, next_pendRd, pendWr, next_pendWr;
   logic [5:0]    spiCnt, next_spiCnt;
   logic [DW-1:0] spiSr, next_spiSr, outSr, next_outSr;
   logic [DW-1:0] spiWdata, next_spiWdata;
   logic [AW-1:0] spiAddr, next_spiAddr;
   logic          rdAct, wrAct, hit, holdAct, spiSel, sckRise, sckFall;

   assign bus.devData   = dataOut;
   assign bus.devDataOe = dataOe;
   assign bus.holdOff   = holdPin;
   assign bus.so        = outSr[DW-1];
   assign bus.soOe      = soOe;

   // ------------------------------------------------------------
   // strap capture and strobe decode
   // ------------------------------------------------------------
   always_comb begin
      next_taken   = taken | strapWait;
      next_style   = style;
      next_wait_polarity_select    = wait_polarity_select;
      next_portPar = portPar;
      if (strapWait && !taken) begin
         next_style   = bus.strobeStyleSelect;
         next_wait_polarity_select    = bus.waitPolaritySelect;
         next_portPar = bus.hostPortSelect;
      end
      if (style) begin
         rdAct = !bus.sharedRwPulseN;
         wrAct = !bus.writeDirN;
      end else begin
         rdAct = !bus.sharedRwPulseN & bus.writeDirN;
         wrAct = !bus.sharedRwPulseN & !bus.writeDirN;
      end
      rdAct  = rdAct & taken & portPar & !bus.chipSelN;
      wrAct  = wrAct & taken & portPar & !bus.chipSelN;
      hit    = pfValid && (bus.addr == pfAddr);
      spiSel  = taken & !portPar & !bus.spiCsN;
      sckRise = bus.sck & !sckPrev;
      sckFall = !bus.sck & sckPrev;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         strapWait <= 1'b0;
         taken     <= 1'b0;
         style     <= STYLE_RST;
         wait_polarity_select      <= WAIT_POLARITY_SELECT_RST;
         portPar   <= PORT_RST;
         sckPrev   <= 1'b0;
      end else begin
         strapWait <= 1'b1;
         taken     <= next_taken;
         style     <= next_style;
         wait_polarity_select      <= next_wait_polarity_select;
         portPar   <= next_portPar;
         sckPrev   <= bus.sck;
      end
   end

   // ------------------------------------------------------------
   // access sequencer
   // ------------------------------------------------------------
   always_comb begin
      next_state     = state;
      next_served    = served;
      next_pfValid   = pfValid;
      next_pfAddr    = pfAddr;
      next_pfData    = pfData;
      next_curAddr   = curAddr;
      next_dataOut   = dataOut;
      next_dataOe    = dataOe;
      next_coreReq   = coreReq;
      next_coreWrite = coreWrite;
      next_coreAddr  = coreAddr;
      next_coreWdata = coreWdata;
      next_spiLoaded = spiLoaded;
      next_spiRead   = spiRead;
      next_pendRd    = pendRd;
      next_pendWr    = pendWr;
      next_spiCnt    = spiCnt;
      next_spiSr     = spiSr;
      next_outSr     = outSr;
      next_spiWdata  = spiWdata;
      next_spiAddr   = spiAddr;
      if (!(rdAct || wrAct)) begin
         next_served = 1'b0;
      end
      // serial shifter
      if (!spiSel) begin
         next_spiCnt    = '0;
         next_spiLoaded = 1'b0;
      end else if (sckRise) begin
         next_spiSr  = {spiSr[DW-2:0], bus.si};
         next_spiCnt = spiCnt + 6'h01;
         if (spiCnt == SPI_HDR - 6'h01) begin
            next_spiRead = spiSr[DW-2];
            next_spiAddr = {spiSr[AW-2:0], bus.si};
            next_pendRd  = spiSr[DW-2];
         end
         if (spiCnt == SPI_FRAME - 6'h01 && !spiRead) begin
            next_spiWdata = {spiSr[DW-2:0], bus.si};
            next_pendWr   = 1'b1;
         end
      end else if (sckFall && spiLoaded && spiCnt > SPI_HDR) begin
         // first data bit stands until the first data rise
         next_outSr = {outSr[DW-2:0], 1'b0};
      end
      unique case (state)
         D_IDLE: begin
            if (rdAct && !served) begin
               next_served  = 1'b1;
               next_curAddr = bus.addr;
               if (hit) begin
                  next_dataOut = pfData;
                  next_dataOe  = 1'b1;
                  next_state   = D_SERVE;
               end else begin
                  next_coreReq   = 1'b1;
                  next_coreWrite = 1'b0;
                  next_coreAddr  = bus.addr;
                  next_state     = D_FETCH;
               end
            end else if (wrAct && !served) begin
               next_served    = 1'b1;
               next_pfValid   = 1'b0;
               next_coreReq   = 1'b1;
               next_coreWrite = 1'b1;
               next_coreAddr  = bus.addr;
               next_coreWdata = bus.dataBus;
               next_state     = D_WRITE;
            end else if (pendRd) begin
               next_pendRd    = 1'b0;
               next_coreReq   = 1'b1;
               next_coreWrite = 1'b0;
               next_coreAddr  = spiAddr;
               next_state     = D_FETCH;
            end else if (pendWr) begin
               next_pendWr    = 1'b0;
               next_coreReq   = 1'b1;
               next_coreWrite = 1'b1;
               next_coreAddr  = spiAddr;
               next_coreWdata = spiWdata;
               next_state     = D_WRITE;
            end
         end
         D_FETCH: begin
            if (coreAck) begin
               next_coreReq = 1'b0;
               if (portPar) begin
                  next_dataOut = coreRdata;
                  next_dataOe  = 1'b1;
                  next_state   = D_SERVE;
               end else begin
                  next_outSr     = coreRdata;
                  next_spiLoaded = spiSel;
                  next_state     = D_IDLE;
               end
            end
         end
         D_SERVE: begin
            if (!rdAct) begin
               next_dataOe    = 1'b0;
               next_pfValid   = 1'b0;
               next_pfAddr    = curAddr + AW'(1);
               next_coreReq   = 1'b1;
               next_coreWrite = 1'b0;
               next_coreAddr  = curAddr + AW'(1);
               next_state     = D_PREF;
            end
         end
         D_PREF: begin
            if (coreAck) begin
               next_coreReq = 1'b0;
               next_pfData  = coreRdata;
               next_pfValid = 1'b1;
               next_state   = D_IDLE;
            end
         end
         D_WRITE: begin
            if (coreAck) begin
               next_coreReq = 1'b0;
               next_state   = D_IDLE;
            end
         end
      endcase
      holdAct = rdAct ? !next_dataOe : (wrAct & !next_served);
      next_holdPin = wait_polarity_select ? holdAct : !holdAct;
      next_soOe = spiSel & next_spiLoaded;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state     <= D_IDLE;
         served    <= 1'b0;
         pfValid   <= 1'b0;
         pfAddr    <= '0;
         pfData    <= '0;
         curAddr   <= '0;
         dataOut   <= '0;
         dataOe    <= 1'b0;
         holdPin   <= 1'b0;
         coreReq   <= 1'b0;
         coreWrite <= 1'b0;
         coreAddr  <= '0;
         coreWdata <= '0;
         spiLoaded <= 1'b0;
         spiRead   <= 1'b0;
         soOe      <= 1'b0;
         pendRd    <= 1'b0;
         pendWr    <= 1'b0;
         spiCnt    <= '0;
         spiSr     <= '0;
         outSr     <= '0;
         spiWdata  <= '0;
         spiAddr   <= '0;
      end else begin
         state     <= next_state;
         served    <= next_served;
         pfValid   <= next_pfValid;
         pfAddr    <= next_pfAddr;
         pfData    <= next_pfData;
         curAddr   <= next_curAddr;
         dataOut   <= next_dataOut;
         dataOe    <= next_dataOe;
         holdPin   <= next_holdPin;
         coreReq   <= next_coreReq;
         coreWrite <= next_coreWrite;
         coreAddr  <= next_coreAddr;
         coreWdata <= next_coreWdata;
         spiLoaded <= next_spiLoaded;
         spiRead   <= next_spiRead;
         soOe      <= next_soOe;
         pendRd    <= next_pendRd;
         pendWr    <= next_pendWr;
         spiCnt    <= next_spiCnt;
         spiSr     <= next_spiSr;
         outSr     <= next_outSr;
         spiWdata  <= next_spiWdata;
         spiAddr   <= next_spiAddr;
      end
   end
endmodule

// >>> src/hbw_host.sv
`timescale 1ns/1ps
module hbw_host
   import hbw_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   hbw_if.host                bus,
   input  wire logic          styleIn,
   input  wire logic          wpolIn,
   input  wire logic          portSelIn,
   input  wire logic          cmdValid,
   input  wire logic          cmdWrite,
   input  wire logic [AW-1:0] cmdAddr,
   input  wire logic [DW-1:0] cmdWdata,
   output logic               cmdReady,
   output logic               rspValid,
   output logic [DW-1:0]      rspData
);
   hbw_host_e     state, next_state;
   logic          style, wait_polarity_select, portSel;
   logic          csN, next_csN, dirN, next_dirN, strN, next_strN;
   logic [AW-1:0] addr, next_addr;
   logic [DW-1:0] wdata, next_wdata;
   logic          dOe, next_dOe, isWr, next_isWr;
   logic          next_cmdReady, next_rspValid;
   logic [DW-1:0] next_rspData;
   logic [3:0]    cnt, next_cnt;
   logic          sCsN, next_sCsN, sck, next_sck, si, next_si;
   logic          gapDone, next_gapDone;
   logic [7:0]    div, next_div;
   logic [5:0]    bits, next_bits;
   logic [31:0]   tx, next_tx;
   logic          waitOff;

   assign bus.strobeStyleSelect  = style;
   assign bus.waitPolaritySelect = wait_polarity_select;
   assign bus.hostPortSelect     = portSel;
   assign bus.chipSelN           = csN;
   assign bus.addr               = addr;
   assign bus.writeDirN          = dirN;
   assign bus.sharedRwPulseN     = strN;
   assign bus.hostData           = wdata;
   assign bus.hostDataOe         = dOe;
   assign bus.spiCsN             = sCsN;
   assign bus.sck                = sck;
   assign bus.si                 = si;

   // ------------------------------------------------------------
   // access sequencer
   // ------------------------------------------------------------
   always_comb begin
      next_state    = state;
      next_csN      = csN;
      next_dirN     = dirN;
      next_strN     = strN;
      next_addr     = addr;
      next_wdata    = wdata;
      next_dOe      = dOe;
      next_isWr     = isWr;
      next_cmdReady = cmdReady;
      next_rspValid = 1'b0;
      next_rspData  = rspData;
      next_cnt      = cnt;
      next_sCsN     = sCsN;
      next_sck      = sck;
      next_si       = si;
      next_gapDone  = gapDone;
      next_div      = div;
      next_bits     = bits;
      next_tx       = tx;
      waitOff       = wait_polarity_select ? !bus.holdOff : bus.holdOff;
      unique case (state)
         H_IDLE: begin
            if (cmdValid && cmdReady) begin
               next_cmdReady = 1'b0;
               next_isWr     = cmdWrite;
               if (portSel) begin
                  next_addr  = cmdAddr;
                  next_wdata = cmdWdata;
                  next_state = H_SETUP;
               end else begin
                  next_sCsN    = 1'b0;
                  next_tx      = {!cmdWrite, cmdAddr, cmdWdata};
                  next_si      = !cmdWrite;
                  next_bits    = '0;
                  next_div     = SPI_HALF;
                  next_gapDone = 1'b0;
                  next_state   = H_SPI;
               end
            end
         end
         H_SETUP: begin
            next_csN = 1'b0;
            next_dOe = isWr;
            next_dirN  = style ? 1'b1 : !isWr;
            next_cnt   = '0;
            next_state = H_STROBE;
         end
         H_STROBE: begin
            // pulse the strobe of the style
            if (style && isWr) begin
               next_dirN = 1'b0;
            end else begin
               next_strN = 1'b0;
            end
            if (cnt < STROBE_MIN) begin
               next_cnt = cnt + 4'h1;
            end else if (waitOff) begin
               next_dirN = style ? 1'b1 : dirN;
               next_strN = 1'b1;
               if (!isWr) begin
                  next_rspData  = bus.dataBus;
                  next_rspValid = 1'b1;
               end
               next_state = H_END;
            end
         end
         H_END: begin
            next_csN      = 1'b1;
            next_dOe      = 1'b0;
            next_dirN     = 1'b1;
            next_cmdReady = 1'b1;
            next_state    = H_IDLE;
         end
         H_SPI: begin
            if (div != 8'h00) begin
               next_div = div - 8'h01;
            end else if (!sck) begin
               if (bits == SPI_HDR && !isWr && !gapDone) begin
                  next_gapDone = 1'b1;
                  next_div     = SPI_GAP;
               end else if (bits == SPI_FRAME) begin
                  next_sCsN     = 1'b1;
                  next_rspValid = !isWr;
                  next_cmdReady = 1'b1;
                  next_state    = H_IDLE;
               end else begin
                  next_sck  = 1'b1;
                  next_bits = bits + 6'h01;
                  next_div  = SPI_HALF;
                  if (bits >= SPI_HDR) begin
                     next_rspData = {rspData[DW-2:0], bus.misoLine};
                  end
               end
            end else begin
               next_sck = 1'b0;
               next_tx  = {tx[30:0], 1'b0};
               next_si  = tx[30];
               next_div = SPI_HALF;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state    <= H_IDLE;
         style    <= STYLE_RST;
         wait_polarity_select     <= WAIT_POLARITY_SELECT_RST;
         portSel  <= PORT_RST;
         csN      <= 1'b1;
         dirN     <= 1'b1;
         strN     <= 1'b1;
         addr     <= '0;
         wdata    <= '0;
         dOe      <= 1'b0;
         isWr     <= 1'b0;
         cmdReady <= 1'b0;
         rspValid <= 1'b0;
         rspData  <= '0;
         cnt      <= '0;
         sCsN     <= 1'b1;
         sck      <= 1'b0;
         si       <= 1'b0;
         gapDone  <= 1'b0;
         div      <= '0;
         bits     <= '0;
         tx       <= '0;
      end else begin
         state    <= next_state;
         style    <= styleIn;
         wait_polarity_select     <= wpolIn;
         portSel  <= portSelIn;
         csN      <= next_csN;
         dirN     <= next_dirN;
         strN     <= next_strN;
         addr     <= next_addr;
         wdata    <= next_wdata;
         dOe      <= next_dOe;
         isWr     <= next_isWr;
         cmdReady <= (state == H_IDLE && !(cmdValid && cmdReady))
                     ? 1'b1 : next_cmdReady;
         rspValid <= next_rspValid;
         rspData  <= next_rspData;
         cnt      <= next_cnt;
         sCsN     <= next_sCsN;
         sck      <= next_sck;
         si       <= next_si;
         gapDone  <= next_gapDone;
         div      <= next_div;
         bits     <= next_bits;
         tx       <= next_tx;
      end
   end
endmodule

// >>> bench/hbw_monitor.sv
`timescale 1ns/1ps
module hbw_monitor #(parameter int DW = 16) (
   input wire logic          clk,
   input wire logic          sys_rst,
   input wire logic          strobeStyleSelect,
   input wire logic          waitPolaritySelect,
   input wire logic          hostPortSelect,
   input wire logic          writeDirN,
   input wire logic          sharedRwPulseN,
   input wire logic          holdOff,
   input wire logic          devDataOe,
   input wire logic [DW-1:0] devData,
   input wire logic          spiCsN,
   input wire logic          soOe
);
   logic rdStb;
   logic waitOn;
   assign rdStb  = !sharedRwPulseN && (strobeStyleSelect || writeDirN);
   assign waitOn = holdOff ~^ waitPolaritySelect;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_served;
      devDataOe && rdStb;
   endsequence
   sequence s_released;
      devDataOe && !rdStb;
   endsequence
   a_oe_stands: assert property (s_served |=> devDataOe)
      else $error("read data dropped while strobe held");
   a_oe_drops: assert property (s_released |=> !devDataOe)
      else $error("read data kept after strobe released");
   a_oe_on_read: assert property ($rose(devDataOe) |-> rdStb && !waitOn)
      else $error("data driven without read strobe or under hold-off");
   a_wait_ends_data: assert property ($fell(waitOn) && rdStb |-> devDataOe)
      else $error("hold-off ended on read without data");
   a_data_stable: assert property (devDataOe && $past(devDataOe)
      |-> $stable(devData))
      else $error("read data changed while driven");
   a_oe_not_write: assert property (devDataOe |-> writeDirN)
      else $error("data driven during write cycle");
   a_wait_bounded: assert property (waitOn |-> ##[1:64] !waitOn)
      else $error("hold-off stuck");
   a_so_released: assert property (spiCsN && $past(spiCsN) |-> !soOe)
      else $error("serial output driven while deselected");
   a_par_no_so: assert property (hostPortSelect && $past(hostPortSelect)
      |-> !soOe)
      else $error("serial output driven in parallel mode");
   a_spi_no_par: assert property (!hostPortSelect && !$past(hostPortSelect)
      |-> !devDataOe)
      else $error("parallel data driven in serial mode");
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import hbw_pkg::*;
   logic clk = 0, sys_rst = 1, style = 1, wait_polarity_select = 1, psel = 1, sawWait = 0;
   logic cmdValid = 0, cmdWrite = 0, cmdReady, rspValid, coreReq, coreWrite;
   logic coreAck = 0;
   logic [14:0] cmdAddr = '0, coreAddr;
   logic [15:0] cmdWdata = '0, rspData, coreWdata, coreRdata = '0, rd;
   logic [15:0] mem [0:31];
   int error_cnt = 0, tests_run = 0, cnt = 0;
   hbw_if #(.AW(15), .DW(16)) link ();
   hbw_dev hbw_dev_inst (.clk(clk), .sys_rst(sys_rst), .bus(link),
      .coreReq(coreReq), .coreWrite(coreWrite), .coreAddr(coreAddr),
      .coreWdata(coreWdata), .coreAck(coreAck), .coreRdata(coreRdata));
   hbw_host hbw_host_inst (.clk(clk), .sys_rst(sys_rst), .bus(link),
      .styleIn(style), .wpolIn(wait_polarity_select), .portSelIn(psel), .cmdValid(cmdValid),
      .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
      .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData));
   hbw_monitor hbw_monitor_inst (.clk(clk), .sys_rst(sys_rst),
      .strobeStyleSelect(link.strobeStyleSelect),
      .waitPolaritySelect(link.waitPolaritySelect),
      .hostPortSelect(link.hostPortSelect), .writeDirN(link.writeDirN),
      .sharedRwPulseN(link.sharedRwPulseN), .holdOff(link.holdOff),
      .devDataOe(link.devDataOe), .devData(link.devData),
      .spiCsN(link.spiCsN), .soOe(link.soOe));
   always #5 clk = ~clk;
   // ------------------------------------------------------------
   // core memory, acks three cycles after request
   // ------------------------------------------------------------
   always @(posedge clk) begin
      #1;
      coreAck = 0;
      if (coreReq === 1'b1 && cnt == 2) begin
         coreAck = 1;
         coreRdata = mem[coreAddr[4:0]];
         if (coreWrite) mem[coreAddr[4:0]] = coreWdata;
         cnt = 0;
      end else if (coreReq === 1'b1) cnt++;
   end
   always @(posedge clk) if (link.holdOff === wait_polarity_select) sawWait <= 1;
   task automatic check(input string nm, input logic [15:0] e, g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic do_reset(input logic s, w, p);
      @(posedge clk); #1;
      sys_rst = 1; style = s; wait_polarity_select = w; psel = p;
      repeat (6) @(posedge clk);
      #1 sys_rst = 0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic xfer(input logic wr, input logic [14:0] a,
                       input logic [15:0] d);
      int n;
      n = 0;
      while (cmdReady !== 1'b1 && n < 3000) begin @(posedge clk); #1; n++; end
      check("ready", 16'h0, {15'h0, n >= 3000});
      sawWait = 0; cmdValid = 1; cmdWrite = wr; cmdAddr = a; cmdWdata = d;
      @(posedge clk); #1;
      cmdValid = 0;
      n = 0;
      while ((wr ? cmdReady : rspValid) !== 1'b1 && n < 3000) begin
         @(posedge clk); #1; n++;
      end
      check("done", 16'h0, {15'h0, n >= 3000});
      rd = rspData;
      repeat (12) @(posedge clk);
      #1;
   endtask
   task automatic t_parallel(input logic s, w, input logic [15:0] v);
      do_reset(s, w, 1'b1);
      xfer(0, 15'h0005, '0);
      check("rd5", 16'hA505, rd);
      check("wait5", 16'h1, {15'h0, sawWait});
      xfer(0, 15'h0006, '0);
      check("rd6", 16'hA506, rd);
      check("wait6", 16'h0, {15'h0, sawWait});
      repeat (40) @(posedge clk);
      #1;
      xfer(0, 15'h0007, '0);
      check("wait7", 16'h0, {15'h0, sawWait});
      xfer(1, 15'h0007, v);
      check("wr7", v, mem[7]);
      xfer(0, 15'h0008, '0);
      check("rd8", 16'hA508, rd);
      check("wait8", 16'h1, {15'h0, sawWait});
      xfer(0, 15'h0007, '0);
      check("rd7", v, rd);
   endtask
   task automatic t_serial;
      do_reset(1'b1, 1'b1, 1'b0);
      xfer(1, 15'h000A, 16'hBEEF);
      check("swr", 16'hBEEF, mem[10]);
      xfer(0, 15'h000A, '0);
      check("srd", 16'hBEEF, rd);
      check("soOe", 16'h0, {15'h0, link.soOe});
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 32; i++) mem[i] = 16'hA500 + 16'(i);
      t_parallel(1'b1, 1'b1, 16'h1234);
      t_parallel(1'b0, 1'b1, 16'h5678);
      t_parallel(1'b1, 1'b0, 16'h9ABC);
      t_parallel(1'b0, 1'b0, 16'hDEF0);
      t_serial;
      test_done;
   end
   initial begin
      #500000;
      error_cnt++;
      test_done;
   end
endmodule
